// ===== design/mkse_params.svh
/*
 Constants for the key-enable and scan-slot block: grid size, key count,
 variant capacities, setup field layout and command codes.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef MKSE_PARAMS_SVH
`define MKSE_PARAMS_SVH
`define MKSE_NUM_DRIVE      8
`define MKSE_NUM_SENSE      6
`define MKSE_NUM_KEYS       48
`define MKSE_KEY_W          6
`define MKSE_CAP_SMALL      6'h20
`define MKSE_CAP_LARGE      6'h30
`define MKSE_SMALL_SENSE    4
`define MKSE_NEG_DETECT_INTEGRATOR_LIMIT_W         4
`define MKSE_BL_W           4
`define MKSE_NEG_DETECT_INTEGRATOR_LIMIT_DEFAULT   4'h2
`define MKSE_BL_DEFAULT     4'h4
`define MKSE_CMD_STATUS     8'h05
`define MKSE_CMD_ENCOUNT    8'h07
`define MKSE_CMD_ERROR      8'h0B
`define MKSE_CMD_SIGNAL_HI  4'h8
`define MKSE_ERR_NONE       8'h00
`define MKSE_ERR_OVERCAP    8'h01
`endif

// ===== design/mkse_pkg.sv
/*
 Types for the key-enable and scan-slot block.
 Assumes the params header is on the include path.
*/
`include "mkse_params.svh"
package mkse_pkg;
    typedef logic [`MKSE_KEY_W-1:0] mkse_key_t;
    typedef struct packed {
        logic [`MKSE_NEG_DETECT_INTEGRATOR_LIMIT_W-1:0] neg_detect_integrator_limit;
        logic [`MKSE_BL_W-1:0]   burst_pulse_count;
    } mkse_setup_s;
    typedef struct packed {
        logic      valid;
        mkse_key_t key;
        logic [`MKSE_BL_W-1:0] burst_pulse_count;
    } mkse_burst_s;
    typedef enum logic [1:0] {MKSE_IDLE, MKSE_BURST, MKSE_WAIT} mkse_scan_e;
endpackage

// ===== design/mkse_scan_seq.sv
/*
 Scan sequencer: walks keys in order, skipping disabled ones, one burst at
 a time. Assumes the acquisition front end pulses burst_done_in once per burst.
*/
`timescale 1ns/1ps
`include "mkse_params.svh"
module mkse_scan_seq (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    // Key enable map and lengths
    input  wire logic [`MKSE_NUM_KEYS-1:0]  enable_in,
    input  wire mkse_pkg::mkse_setup_s      setup_in [`MKSE_NUM_KEYS],
    // Front end
    input  wire logic                       burst_done_in,
    output mkse_pkg::mkse_burst_s           burst_out,
    output logic                            frame_done_out
);
    mkse_pkg::mkse_scan_e state;
    mkse_pkg::mkse_scan_e next_state;
    mkse_pkg::mkse_key_t  key;
    mkse_pkg::mkse_key_t  next_key;
    mkse_pkg::mkse_burst_s next_burst;
    logic                 next_frame_done;

    // Next enabled key at or after a start point, or 7'h7F when none is left in the frame
    function automatic logic [6:0] find_next(input logic [`MKSE_NUM_KEYS-1:0] en,
                                             input logic [6:0] start);
        logic [6:0] res;
        res = 7'h7F;
        for (int i = `MKSE_NUM_KEYS - 1; i >= 0; i--) begin
            if (en[i] && (7'(i) >= start)) begin
                res = 7'(i);
            end
        end
        return res;
    endfunction

    always_comb begin
        logic [6:0] nk;
        nk = 7'h00;
        next_state = state;
        next_key = key;
        next_burst = burst_out;
        next_frame_done = 1'b0;
        case (state)
            mkse_pkg::MKSE_IDLE: begin
                nk = find_next(enable_in, {1'b0, key});
                if (nk != 7'h7F) begin
                    next_key = nk[5:0];
                    next_burst = '{1'b1, nk[5:0], setup_in[nk[5:0]].burst_pulse_count};
                    next_state = mkse_pkg::MKSE_BURST;
                end else begin
                    next_key = '0;
                    next_frame_done = (key != '0);
                end
            end
            mkse_pkg::MKSE_BURST: begin
                if (burst_done_in) begin
                    next_burst.valid = 1'b0;
                    next_state = mkse_pkg::MKSE_WAIT;
                end
            end
            mkse_pkg::MKSE_WAIT: begin
                next_key = (key == 6'(`MKSE_NUM_KEYS - 1)) ? '0 : key + 6'h01;
                next_frame_done = (key == 6'(`MKSE_NUM_KEYS - 1));
                next_state = mkse_pkg::MKSE_IDLE;
            end
            default: next_state = mkse_pkg::MKSE_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= mkse_pkg::MKSE_IDLE;
            key <= '0;
            burst_out <= '0;
            frame_done_out <= 1'b0;
        end else begin
            state <= next_state;
            key <= next_key;
            burst_out <= next_burst;
            frame_done_out <= next_frame_done;
        end
    end

    burst_held_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (burst_out.valid && !burst_done_in) |=> burst_out.valid && $stable(burst_out.key))
        else $error("burst dropped before done");
    burst_enabled_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (next_burst.valid && !burst_out.valid) |-> enable_in[next_burst.key])
        else $error("disabled key bursted");
endmodule

// ===== design/mkse_top.sv
/*
 Key-enable and scan-slot allocation: holds per-key setups, stages whole
 setup-block loads, checks the variant capacity, runs the scan and answers
 single-byte host commands. Assumes serial framing is done outside on clk_in.
*/
`timescale 1ns/1ps
`include "mkse_params.svh"
module mkse_top #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    // Setup block load, one key per beat
    input  wire logic                      load_valid_in,
    input  wire mkse_pkg::mkse_key_t       load_key_in,
    input  wire mkse_pkg::mkse_setup_s     load_setup_in,
    input  wire logic                      load_commit_in,
    input  wire logic                      defaults_in,
    // Commands
    input  wire logic                      cmd_valid_in,
    input  wire logic [7:0]                cmd_in,
    output logic                           resp_valid_out,
    output logic [7:0]                     resp_out,
    // Measured signals from front end
    input  wire logic                      sig_valid_in,
    input  wire logic [7:0]                sig_in,
    // Acquisition front end
    input  wire logic                      burst_done_in,
    output mkse_pkg::mkse_burst_s          burst_out,
    output logic                           frame_done_out,
    output logic [`MKSE_KEY_W-1:0]         enabled_count_out
);
    localparam logic [5:0] CAP = LARGE_VARIANT ? `MKSE_CAP_LARGE : `MKSE_CAP_SMALL;

    mkse_pkg::mkse_setup_s setup      [`MKSE_NUM_KEYS];
    mkse_pkg::mkse_setup_s next_setup [`MKSE_NUM_KEYS];
    mkse_pkg::mkse_setup_s stage      [`MKSE_NUM_KEYS];
    mkse_pkg::mkse_setup_s next_stage [`MKSE_NUM_KEYS];
    logic [7:0]            signal      [`MKSE_NUM_KEYS];
    logic [7:0]            next_signal [`MKSE_NUM_KEYS];
    logic [`MKSE_NUM_KEYS-1:0] enable;
    logic [7:0]            error_code;
    logic [7:0]            next_error_code;
    logic                  next_resp_valid;
    logic [7:0]            next_resp;
    logic [5:0]            next_count;

    function automatic logic [`MKSE_NUM_KEYS-1:0] en_map(
        input mkse_pkg::mkse_setup_s s [`MKSE_NUM_KEYS]);
        logic [`MKSE_NUM_KEYS-1:0] m;
        m = '0;
        for (int i = 0; i < `MKSE_NUM_KEYS; i++) begin
            m[i] = (s[i].neg_detect_integrator_limit != '0);
        end
        return m;
    endfunction

    function automatic logic [5:0] pop(input logic [`MKSE_NUM_KEYS-1:0] m);
        logic [5:0] c;
        c = '0;
        for (int i = 0; i < `MKSE_NUM_KEYS; i++) begin
            c = c + 6'(m[i]);
        end
        return c;
    endfunction

    function automatic logic [2:0] sense_of(input int k);
        return 3'(k / `MKSE_NUM_DRIVE);
    endfunction

    assign enable = en_map(setup);

    always_comb begin
        logic [`MKSE_NUM_KEYS-1:0] new_map;
        new_map = en_map(stage);
        next_setup = setup;
        next_stage = stage;
        next_error_code = error_code;
        next_count = enabled_count_out;
        if (defaults_in) begin
            for (int i = 0; i < `MKSE_NUM_KEYS; i++) begin
                next_setup[i].burst_pulse_count = `MKSE_BL_DEFAULT;
                next_setup[i].neg_detect_integrator_limit =
                    (LARGE_VARIANT || sense_of(i) < 3'(`MKSE_SMALL_SENSE))
                    ? `MKSE_NEG_DETECT_INTEGRATOR_LIMIT_DEFAULT : '0;
            end
            next_stage = next_setup;
            next_error_code = `MKSE_ERR_NONE;
        end else if (load_commit_in) begin
            if (pop(new_map) <= CAP) begin
                next_setup = stage;
                next_error_code = `MKSE_ERR_NONE;
            end else begin
                next_stage = setup;
                next_error_code = `MKSE_ERR_OVERCAP;
            end
        end else if (load_valid_in && (load_key_in < 6'(`MKSE_NUM_KEYS))) begin
            next_stage[load_key_in] = load_setup_in;
        end
        next_count = pop(en_map(next_setup));
    end

    always_comb begin
        next_signal = signal;
        if (sig_valid_in && burst_out.valid) begin
            next_signal[burst_out.key] = sig_in;
        end
    end

    always_comb begin
        next_resp_valid = 1'b0;
        next_resp = resp_out;
        if (cmd_valid_in) begin
            next_resp_valid = 1'b1;
            if (cmd_in[7:4] == `MKSE_CMD_SIGNAL_HI && {2'b00, cmd_in[3:0]} < 6'h30) begin
                next_resp = signal[6'(cmd_in[3:0])];
            end else if (cmd_in == `MKSE_CMD_ERROR) begin
                next_resp = error_code;
            end else if (cmd_in == `MKSE_CMD_ENCOUNT) begin
                next_resp = {2'b00, enabled_count_out};
            end else begin
                next_resp = cmd_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < `MKSE_NUM_KEYS; i++) begin
                setup[i] <= '0;
                stage[i] <= '0;
                signal[i] <= 8'h00;
            end
            error_code <= `MKSE_ERR_NONE;
            enabled_count_out <= '0;
            resp_valid_out <= 1'b0;
            resp_out <= 8'h00;
        end else begin
            setup <= next_setup;
            stage <= next_stage;
            signal <= next_signal;
            error_code <= next_error_code;
            enabled_count_out <= next_count;
            resp_valid_out <= next_resp_valid;
            resp_out <= next_resp;
        end
    end

    mkse_scan_seq u_seq (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .enable_in      (enable),
        .setup_in       (setup),
        .burst_done_in  (burst_done_in),
        .burst_out      (burst_out),
        .frame_done_out (frame_done_out)
    );

    cap_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        enabled_count_out <= CAP)
        else $error("enabled keys above capacity");
    overcap_refused_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (load_commit_in && !defaults_in && pop(en_map(stage)) > CAP) |=>
        (error_code == `MKSE_ERR_OVERCAP) && $stable(enable))
        else $error("overfull block applied");
    small_default_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (defaults_in && !LARGE_VARIANT) |=> enable[47:32] == 16'h0000)
        else $error("Y4/Y5 enabled by defaults");
    swap_apply_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (load_commit_in && !defaults_in && pop(en_map(stage)) <= CAP) |=>
        enable == $past(en_map(stage)))
        else $error("valid block not applied");
    cmd_answer_a: assert property (@(posedge clk_in) disable iff (rst_in)
        cmd_valid_in |=> resp_valid_out ##1 !resp_valid_out || $past(cmd_valid_in))
        else $error("command not answered");
    zero_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        enable[0] == (setup[0].neg_detect_integrator_limit != '0))
        else $error("enable map mismatch");
    err_report_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_valid_in && cmd_in == `MKSE_CMD_ERROR) |=> resp_out == $past(error_code))
        else $error("error report wrong");
    // last burst key of this frame
    logic       order_armed;
    logic [5:0] order_key;
    always_ff @(posedge clk_in) begin
        if (rst_in || frame_done_out) begin
            order_armed <= 1'b0;
            order_key   <= '0;
        end else if (burst_out.valid) begin
            order_armed <= 1'b1;
            order_key   <= burst_out.key;
        end
    end
    scan_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ($rose(burst_out.valid) && order_armed) |-> burst_out.key > order_key)
        else $error("scan order broken");

    commit_c: cover property (@(posedge clk_in) load_commit_in ##1 error_code == 8'h00);
    overcap_c: cover property (@(posedge clk_in) error_code == `MKSE_ERR_OVERCAP);
    frame_c: cover property (@(posedge clk_in) frame_done_out);
endmodule

// ===== verification/matrix_key_slot_enable_tb.sv
/*
 Self-checking bench for the 32-key build: defaults, scan order, commands,
 refused and accepted setup loads. Assumes the front end model.
*/
`timescale 1ns/1ps
module matrix_key_slot_enable_tb;
    logic                  clk_in;
    logic                  rst_in;
    logic                  load_valid_in;
    mkse_pkg::mkse_key_t   load_key_in;
    mkse_pkg::mkse_setup_s load_setup_in;
    logic                  load_commit_in;
    logic                  defaults_in;
    logic                  cmd_valid_in;
    logic [7:0]            cmd_in;
    logic                  resp_valid_out;
    logic [7:0]            resp_out;
    logic                  sig_valid_in;
    logic [7:0]            sig_in;
    logic                  burst_done_in;
    mkse_pkg::mkse_burst_s burst_out;
    logic                  frame_done_out;
    logic [5:0]            enabled_count_out;
    logic [5:0]            count_l;
    logic [3:0]            delay;
    logic                  hold;
    logic                  scan_chk;
    logic                  armed;
    logic                  prev_v;
    int                    mismatches;
    int                    checks;
    int                    seed;
    int                    last;
    int                    frames;
    int                    i;
    int                    j;
    int                    lim [48];
    int                    stg [48];
    int                    bl [48];
    int                    sbl [48];
    int                    sigm [48];

    mkse_top #(.LARGE_VARIANT(1'b0)) DUT (.clk_in(clk_in), .rst_in(rst_in),
        .load_valid_in(load_valid_in), .load_key_in(load_key_in),
        .load_setup_in(load_setup_in), .load_commit_in(load_commit_in),
        .defaults_in(defaults_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .resp_valid_out(resp_valid_out), .resp_out(resp_out),
        .sig_valid_in(sig_valid_in), .sig_in(sig_in), .burst_done_in(burst_done_in),
        .burst_out(burst_out), .frame_done_out(frame_done_out),
        .enabled_count_out(enabled_count_out));
    mkse_top #(.LARGE_VARIANT(1'b1)) DUT_L (.clk_in(clk_in), .rst_in(rst_in),
        .load_valid_in(load_valid_in), .load_key_in(load_key_in),
        .load_setup_in(load_setup_in), .load_commit_in(load_commit_in),
        .defaults_in(defaults_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .resp_valid_out(), .resp_out(), .sig_valid_in(sig_valid_in), .sig_in(sig_in),
        .burst_done_in(burst_done_in), .burst_out(), .frame_done_out(),
        .enabled_count_out(count_l));
    mkse_front_end_model FE (.clk_in(clk_in), .burst_in(burst_out), .delay_in(delay),
        .hold_in(hold), .burst_done_out(burst_done_in), .sig_valid_out(sig_valid_in),
        .sig_out(sig_in));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic step;
        @(posedge clk_in);
        #1;
    endtask

    function automatic int count(input int a [48]);
        count = 0;
        foreach (a[n]) count += (a[n] != 0);
    endfunction

    task automatic load(input int k, input int l, input int b);
        load_valid_in = 1'b1;
        load_key_in   = 6'(k);
        load_setup_in = {4'(l), 4'(b)};
        stg[k] = l;
        sbl[k] = b;
        step();
    endtask

    task automatic commit;
        load_valid_in  = 1'b0;
        load_commit_in = 1'b1;
        step();
        load_commit_in = 1'b0;
        // Capacity judged on the whole staged block
        if (count(stg) <= 32) begin
            lim = stg;
            bl  = sbl;
        end else begin
            stg = lim;
            sbl = bl;
        end
        step();
        check(8'(enabled_count_out), 8'(count(lim)));
    endtask

    task automatic cmd(input logic [7:0] c, input int exp);
        int w;
        cmd_valid_in = 1'b1;
        cmd_in       = c;
        step();
        cmd_valid_in = 1'b0;
        w = 0;
        while (resp_valid_out !== 1'b1 && w < 3) begin
            step();
            w++;
        end
        check(8'(resp_valid_out), 8'h01);
        check(resp_out, 8'(exp));
        step();
    endtask

    task automatic wait_frames(input int n);
        int f;
        int w;
        f = frames + n;
        w = 0;
        while (frames < f && w < 4000) begin
            step();
            w++;
        end
        check(8'(frames >= f), 8'h01);
    endtask

    always @(posedge clk_in) begin
        int k;
        if (sig_valid_in === 1'b1) sigm[burst_out.key] = sig_in;
        if (burst_out.valid === 1'b1 && prev_v !== 1'b1 && armed) begin
            k = last + 1;
            while (k < 48 && lim[k] == 0) k++;
            check(8'(burst_out.key), 8'(k));
            check(8'(burst_out.burst_pulse_count), 8'(bl[k % 48]));
            last = burst_out.key;
        end
        if (frame_done_out === 1'b1) begin
            k = last + 1;
            while (k < 48 && lim[k] == 0) k++;
            if (armed) check(8'(k), 8'h30);
            frames++;
            armed = scan_chk;
            last  = -1;
        end
        if (!scan_chk) armed = 1'b0;
        prev_v = burst_out.valid;
    end

    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end

    initial begin
        seed = 32'h73CAC307;
        {load_valid_in, load_commit_in, defaults_in, cmd_valid_in, hold} = 5'h00;
        {load_key_in, load_setup_in, cmd_in} = 22'h000000;
        {scan_chk, armed, prev_v} = 3'h0;
        delay  = 4'h2;
        frames = 0;
        last   = -1;
        foreach (lim[n]) begin
            {lim[n], stg[n], bl[n], sbl[n], sigm[n]} = 160'h0;
        end
        rst_in = 1'b1;
        repeat (3) step();
        rst_in = 1'b0;
        check(8'(enabled_count_out), 8'h00);
        defaults_in = 1'b1;
        step();
        defaults_in = 1'b0;
        foreach (lim[n]) begin
            stg[n] = (n < 32) ? 2 : 0;
            sbl[n] = 4;
        end
        lim = stg;
        bl  = sbl;
        repeat (2) step();
        check(8'(enabled_count_out), 8'h20);
        check(8'(count_l), 8'h30);
        scan_chk = 1'b1;
        repeat (3) begin
            delay = 4'($random(seed));
            wait_frames(1);
        end
        // Stall the front end so signal bytes stay put
        scan_chk = 1'b0;
        hold     = 1'b1;
        repeat (24) step();
        cmd(8'h07, 32);
        cmd(8'h0B, 0);
        repeat (8) begin
            i = $random(seed) & 15;
            cmd(8'h80 | 8'(i), sigm[i]);
        end
        repeat (6) begin
            i = 16 + ($random(seed) & 63);
            cmd(8'(i), i);
        end
        load(40, 5, 9);
        commit();
        cmd(8'h0B, 1);
        commit();
        load(0, 0, 4);
        load(40, 1 + ($random(seed) & 7), $random(seed) & 15);
        commit();
        hold     = 1'b0;
        scan_chk = 1'b1;
        wait_frames(2);
        repeat (4) begin
            scan_chk = 1'b0;
            i = $random(seed) & 31;
            j = 32 + ($random(seed) & 15);
            load(i, 0, 4);
            load(j, 1 + ($random(seed) & 7), $random(seed) & 15);
            commit();
            scan_chk = 1'b1;
            wait_frames(2);
        end
        print_verdict();
    end
endmodule

// ===== verification/mkse_front_end_model.sv
/*
 Front end model: answers each burst with one signal byte, then a done.
 Assumes burst valid stands until the edge after done.
*/
`timescale 1ns/1ps
module mkse_front_end_model (
    // Clock and burst
    input  wire logic                  clk_in,
    input  wire mkse_pkg::mkse_burst_s burst_in,
    // Pacing
    input  wire logic [3:0]            delay_in,
    input  wire logic                  hold_in,
    // Answers
    output logic                       burst_done_out,
    output logic                       sig_valid_out,
    output logic [7:0]                 sig_out
);
    initial begin
        burst_done_out = 1'b0;
        sig_valid_out  = 1'b0;
        sig_out        = 8'h00;
        forever begin
            @(posedge clk_in);
            if (burst_in.valid === 1'b1 && hold_in === 1'b0) begin
                repeat (delay_in) @(posedge clk_in);
                #1;
                sig_out       = {burst_in.key, 2'h0} ^ {4'h0, delay_in};
                sig_valid_out = 1'b1;
                @(posedge clk_in);
                #1;
                // Released line shows garbage, not the last value
                sig_out        = ~sig_out;
                sig_valid_out  = 1'b0;
                burst_done_out = 1'b1;
                @(posedge clk_in);
                #1;
                burst_done_out = 1'b0;
                while (burst_in.valid === 1'b1) @(posedge clk_in);
            end
        end
    end
endmodule
